// >>> design/acsrp_port.sv
`timescale 1ns/100ps
`default_nettype none
`include "acsrp_defines.svh"

module acsrp_port #(
    parameter logic [7:0] CONV_MCLK  = `ACSRP_CONV_MCLK,
    parameter logic [7:0] CAL_MCLK   = `ACSRP_CAL_MCLK,
    parameter int         FIFO_DEPTH = `ACSRP_FIFO_DEPTH
) (
    input  wire logic                     core_clk,
    input  wire logic                     srst,
    input  wire logic                     sclk,
    input  wire logic                     sync_n,
    input  wire logic                     din_in,
    output logic                          din_out,
    output logic                          din_oe_n,
    output logic                          dout,
    input  wire logic                     master_clock_in,
    input  wire logic [13:0]              result_data,
    input  wire logic                     result_valid,
    output logic                          result_ready,
    output acsrp_pkg::acsrp_core_t        core
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0]                  sclk_s;
        logic [1:0]                  sync_s;
        logic [1:0]                  din_s;
        logic [1:0]                  mclk_s;
        logic                        sclk_d;
        logic                        mclk_d;
        acsrp_pkg::acsrp_frame_t     fr;
        logic [4:0]                  bits;
        logic [15:0]                 sh_in;
        logic [15:0]                 sh_out;
        logic                        rd_drive;
        acsrp_pkg::acsrp_ctrl_t      ctrl;
        logic [13:0]                 test;
        logic [9:0][13:0]            cal;
        logic [3:0]                  cal_idx;
        logic [13:0]                 data;
        logic                        busy;
        logic                        cal_run;
        logic [7:0]                  tmr;
        logic                        conv_pulse;
        logic                        cal_pulse;
    } acsrp_state_t;

    acsrp_state_t r, n;

    logic        sclk_rise, sclk_fall, mclk_rise;
    logic        frame_start, frame_end, wr_done;
    logic [15:0] wr_word;
    logic [1:0]  rsel;
    logic [13:0] status_word, fifo_data;
    logic        fifo_valid, fifo_pop;
    logic [15:0] rd_word;

    // ------------------------------------------------------------
    // Result buffer
    // ------------------------------------------------------------
    acsrp_fifo #(
        .W     (14),
        .DEPTH (FIFO_DEPTH)
    ) i_acsrp_fifo (
        .core_clk  (core_clk),
        .srst      (srst),
        .in_data   (result_data),
        .in_valid  (result_valid),
        .in_ready  (result_ready),
        .out_data  (fifo_data),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop)
    );

    // ------------------------------------------------------------
    // Edges and frame events
    // ------------------------------------------------------------
    // Edges are taken from the second sync stage only
    assign sclk_rise   = r.sclk_s[1] && !r.sclk_d;
    assign sclk_fall   = !r.sclk_s[1] && r.sclk_d;
    assign mclk_rise   = r.mclk_s[1] && !r.mclk_d;
    assign frame_start = (r.fr == acsrp_pkg::FR_IDLE) && !r.sync_s[1];
    assign frame_end   = (r.fr == acsrp_pkg::FR_SHIFT) && r.sync_s[1];
    assign wr_word     = {r.sh_in[14:0], r.din_s[1]};
    // A write lands only on the sixteenth sampled bit of a frame
    assign wr_done     = (r.fr == acsrp_pkg::FR_SHIFT) && !r.sync_s[1]
                         && sclk_rise && (r.bits == 5'h0f)
                         && !r.rd_drive;
    assign rsel        = {r.ctrl.read_select_hi, r.ctrl.read_select_lo};
    assign status_word = {r.busy, r.cal_run, rsel, r.ctrl.two_wire_mode,
                          fifo_valid, 8'h00};
    // Fresh result is popped as the read frame opens
    assign fifo_pop    = frame_start && (rsel == `ACSRP_RSEL_DATA)
                         && fifo_valid;

    always_comb begin
        rd_word = 16'h0000;
        if (rsel == `ACSRP_RSEL_DATA) begin
            rd_word = {2'b00, fifo_pop ? fifo_data : r.data};
        end else if (rsel == `ACSRP_RSEL_TEST) begin
            rd_word = {2'b00, r.test};
        end else if (rsel == `ACSRP_RSEL_CAL) begin
            rd_word = {2'b00, r.cal[r.cal_idx]};
        end else begin
            rd_word = {2'b00, status_word};
        end
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        n = r;
        n.sclk_s     = {r.sclk_s[0], sclk};
        n.sync_s     = {r.sync_s[0], sync_n};
        n.din_s      = {r.din_s[0], din_in};
        n.mclk_s     = {r.mclk_s[0], master_clock_in};
        n.sclk_d     = r.sclk_s[1];
        n.mclk_d     = r.mclk_s[1];
        n.conv_pulse = 1'b0;
        n.cal_pulse  = 1'b0;

        if (r.fr == acsrp_pkg::FR_IDLE) begin
            n.bits = 5'h00;
            if (frame_start) begin
                n.fr       = acsrp_pkg::FR_SHIFT;
                n.sh_out   = rd_word;
                n.rd_drive = r.ctrl.two_wire_mode;
                if (fifo_pop) begin
                    n.data = fifo_data;
                end
            end
        end else if (frame_end) begin
            // Partial words are dropped with the frame
            n.fr       = acsrp_pkg::FR_IDLE;
            n.bits     = 5'h00;
            n.rd_drive = 1'b0;
            if (r.rd_drive) begin
                n.ctrl.two_wire_mode = 1'b0;
            end
        end else begin
            if (sclk_rise && (r.bits != 5'h10)) begin
                n.sh_in = wr_word;
                n.bits  = r.bits + 5'h01;
            end
            if (sclk_fall && (r.bits != 5'h00) && (r.bits != 5'h10)) begin
                n.sh_out = {r.sh_out[14:0], 1'b0};
            end
        end

        if (wr_done) begin
            if (wr_word[15:14] == `ACSRP_WADDR_TEST) begin
                n.test = wr_word[13:0];
            end else if (wr_word[15:14] == `ACSRP_WADDR_CAL) begin
                n.cal[r.cal_idx] = wr_word[13:0];
                n.cal_idx = (r.cal_idx == 4'(`ACSRP_CAL_REGS - 1))
                            ? 4'h0 : r.cal_idx + 4'h1;
            end else if (wr_word[15:14] == `ACSRP_WADDR_CTRL) begin
                n.ctrl    = acsrp_pkg::acsrp_ctrl_t'(wr_word[13:0]);
                n.cal_idx = 4'h0;
                // A start while busy is dropped; the engine runs one job
                if (!r.busy && wr_word[0]) begin
                    n.busy      = 1'b1;
                    n.cal_run   = 1'b1;
                    n.tmr       = CAL_MCLK;
                    n.cal_pulse = 1'b1;
                end else if (!r.busy && wr_word[4]) begin
                    n.busy       = 1'b1;
                    n.tmr        = CONV_MCLK;
                    n.conv_pulse = 1'b1;
                end
            end
        end

        // Timer ticks on master clock edges, not on the core clock
        // It follows the write so a dropped start never outlives the job
        if (r.busy && mclk_rise) begin
            n.tmr = r.tmr - 8'h01;
            if (r.tmr == 8'h01) begin
                n.busy              = 1'b0;
                n.cal_run           = 1'b0;
                n.ctrl.soft_convert = 1'b0;
                n.ctrl.start_cal    = 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            r      <= '0;
            r.ctrl <= acsrp_pkg::acsrp_ctrl_t'(`ACSRP_CTRL_RESET);
            r.sclk_s <= 2'b00;
            r.sync_s <= 2'b11;
            r.sclk_d <= 1'b0;
        end else begin
            r <= n;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Serial clock is only ever an input here
    assign dout     = r.sh_out[15];
    assign din_out  = r.sh_out[15];
    assign din_oe_n = !((r.fr == acsrp_pkg::FR_SHIFT) && r.rd_drive);
    assign core     = {r.conv_pulse, r.cal_pulse, r.busy, r.ctrl};

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    chk_bits_clear: assert property (frame_end |=> r.bits == 5'h00)
        else $error("bit counter not cleared at frame end");
    chk_drive_open: assert property (
        frame_start && r.ctrl.two_wire_mode |=> !din_oe_n)
        else $error("two-wire read frame does not drive data-in");
    chk_mode_clear: assert property (
        frame_end && r.rd_drive |=> !r.ctrl.two_wire_mode ##1 din_oe_n)
        else $error("interface mode not cleared after read");
    chk_lead_zero: assert property (
        frame_start |=> r.sh_out[15:14] == 2'b00)
        else $error("read word lacks two leading zeros");
    chk_test_write: assert property (
        wr_done && wr_word[15:14] == `ACSRP_WADDR_TEST
        |=> r.test == $past(wr_word[13:0]))
        else $error("test write not latched");
    chk_addr_none: assert property (
        wr_done && wr_word[15:14] == `ACSRP_WADDR_NONE
        |=> $stable(r.test) && $stable(r.cal_idx))
        else $error("address 00 changed a register");
    chk_partial_drop: assert property (
        frame_end && r.bits != 5'h10 |=> $stable(r.test) && $stable(r.cal))
        else $error("partial word changed a register");
    chk_bit_count: assert property (
        r.fr == acsrp_pkg::FR_SHIFT && !r.sync_s[1] && sclk_rise
        && r.bits != 5'h10 |=> r.bits == $past(r.bits) + 5'h01)
        else $error("bit counter did not advance");
    chk_idle_hold: assert property (
        r.fr == acsrp_pkg::FR_IDLE && r.sync_s[1] |=> $stable(r.sh_in))
        else $error("bits shifted outside a frame");
    chk_conv_busy: assert property (
        r.conv_pulse |-> r.busy && r.tmr == CONV_MCLK)
        else $error("conversion start without timer load");

    // ------------------------------------------------------------
    // Frame, register and timer checks
    // ------------------------------------------------------------
    chk_frame_open: assert property (
        frame_start |=> r.fr == acsrp_pkg::FR_SHIFT && r.bits == 5'h00)
        else $error("frame did not open with a cleared counter");
    chk_shift_step: assert property (
        r.fr == acsrp_pkg::FR_SHIFT && !r.sync_s[1] && sclk_fall
        && r.bits != 5'h00 && r.bits != 5'h10
        |=> r.sh_out == {$past(r.sh_out[14:0]), 1'b0})
        else $error("read word did not shift on a falling edge");
    chk_out_hold: assert property (
        r.fr == acsrp_pkg::FR_IDLE && !frame_start |=> $stable(r.sh_out))
        else $error("read word moved outside a frame");
    chk_drive_nowrite: assert property (
        r.rd_drive |-> !wr_done)
        else $error("write accepted while driving data-in");
    chk_cal_write: assert property (
        wr_done && wr_word[15:14] == `ACSRP_WADDR_CAL
        |=> r.cal[$past(r.cal_idx)] == $past(wr_word[13:0]))
        else $error("calibration write not latched");
    chk_cal_index: assert property (
        r.cal_idx <= 4'(`ACSRP_CAL_REGS - 1))
        else $error("calibration index out of range");
    chk_ctrl_write: assert property (
        wr_done && wr_word[15:14] == `ACSRP_WADDR_CTRL
        |=> r.ctrl[13:5] == $past(wr_word[13:5]))
        else $error("control write not latched");
    chk_ctrl_hold: assert property (
        !(wr_done && wr_word[15:14] == `ACSRP_WADDR_CTRL)
        |=> $stable(r.ctrl[13:6]))
        else $error("control changed without a control write");
    chk_data_hold: assert property (
        !fifo_pop |=> $stable(r.data))
        else $error("output data changed without a new result");
    chk_busy_drop: assert property (
        wr_done && r.busy |=> !r.conv_pulse && !r.cal_pulse)
        else $error("start accepted while busy");
    chk_cal_busy: assert property (
        r.cal_pulse |-> r.busy && r.cal_run && r.tmr == CAL_MCLK)
        else $error("calibration start without timer load");
    chk_start_clear: assert property (
        $fell(r.busy) |-> !r.ctrl.soft_convert && !r.ctrl.start_cal)
        else $error("start bit left set after the job ended");

    cov_ctrl_write: cover property (
        wr_done && wr_word[15:14] == `ACSRP_WADDR_CTRL);
    cov_status_read: cover property (
        frame_start && rsel == `ACSRP_RSEL_STATUS);
    cov_two_wire: cover property (!din_oe_n ##1 din_oe_n);
    cov_conv_done: cover property (r.busy ##1 !r.busy);
    cov_cal_done: cover property (r.cal_run ##1 !r.cal_run);

endmodule

`default_nettype wire

// >>> design/acsrp_defines.svh
// What this block does
// - Every read frame shifts one 16-bit word out on the data-out line.
// - Data-in is input only, or two-way, as the interface mode selects.
// - Conversion and calibration timing counts master clock edges.
// - Frame sync is active-low level; bits move only inside a frame.
// - Power-up defaults work with only a channel configuration write.
// - Other power-down, calibration and soft start need further writes.
// - Control write-only; data and status read-only; test, cal read/write.
// - Top two bits are the address, 14 data bits latch after bit 16.
// - Address 00 ignored, 01 test, 10 calibration, 11 control.
// - Persistent read-select bits, reset 00: data, test, cal, status.
// - Output data reads carry two leading zeros before the 14-bit result.
`ifndef ACSRP_DEFINES_SVH
`define ACSRP_DEFINES_SVH

`define ACSRP_WORD_BITS     16
`define ACSRP_DATA_BITS     14
`define ACSRP_CAL_REGS      10
`define ACSRP_FIFO_DEPTH    32
`define ACSRP_WADDR_NONE    2'h0
`define ACSRP_WADDR_TEST    2'h1
`define ACSRP_WADDR_CAL     2'h2
`define ACSRP_WADDR_CTRL    2'h3
`define ACSRP_RSEL_DATA     2'h0
`define ACSRP_RSEL_TEST     2'h1
`define ACSRP_RSEL_CAL      2'h2
`define ACSRP_RSEL_STATUS   2'h3
`define ACSRP_CTRL_RESET    14'h0000
`define ACSRP_CONV_MCLK     8'h10
`define ACSRP_CAL_MCLK      8'h40

`endif

// >>> design/acsrp_pkg.sv
package acsrp_pkg;

    // Control word, most significant field first
    typedef struct packed {
        logic       single_ended;
        logic [2:0] channel;
        logic [1:0] power_mgmt;
        logic       read_select_hi;
        logic       read_select_lo;
        logic       two_wire_mode;
        logic       soft_convert;
        logic       cal_mode;
        logic [1:0] cal_select;
        logic       start_cal;
    } acsrp_ctrl_t;

    typedef enum logic {
        FR_IDLE,
        FR_SHIFT
    } acsrp_frame_t;

    typedef struct packed {
        logic        conv_start;
        logic        cal_start;
        logic        busy;
        acsrp_ctrl_t ctrl;
    } acsrp_core_t;

endpackage

// >>> design/acsrp_fifo.sv
`timescale 1ns/100ps
`default_nettype none

module acsrp_fifo #(
    parameter int W     = 14,
    parameter int DEPTH = 32
) (
    input  wire logic         core_clk,
    input  wire logic         srst,
    input  wire logic [W-1:0] in_data,
    input  wire logic         in_valid,
    output logic              in_ready,
    output logic [W-1:0]      out_data,
    output logic              out_valid,
    input  wire logic         out_ready
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0]           wr;
        logic [AW-1:0]           rd;
        logic [AW:0]             cnt;
    } acsrp_fifo_state_t;

    acsrp_fifo_state_t r, n;
    logic push, pop;

    assign in_ready  = (r.cnt != (AW+1)'(DEPTH));
    assign out_valid = (r.cnt != '0);
    assign out_data  = r.mem[r.rd];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        n = r;
        if (push) begin
            n.mem[r.wr] = in_data;
            n.wr = (r.wr == AW'(DEPTH-1)) ? '0 : r.wr + 1'b1;
        end
        if (pop) begin
            n.rd = (r.rd == AW'(DEPTH-1)) ? '0 : r.rd + 1'b1;
        end
        n.cnt = r.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

endmodule

`default_nettype wire

// >>> verification/acsrp_host_model.sv
`timescale 1ns/100ps
`default_nettype none

module acsrp_host_model (
    output var logic sclk,
    output var logic sync_n,
    output var logic host_din,
    input  wire logic dout,
    input  wire logic din_wire
);
    initial begin
        sclk     = 1'b0;
        sync_n   = 1'b1;
        host_din = 1'b0;
    end

    // ------------------------------------------------------------
    // One frame, msb first; the serial clock stands still outside it
    // ------------------------------------------------------------
    task automatic xfer(input logic [15:0] wr, input int nbits,
                        input logic rel, output logic [15:0] rd);
        rd     = 16'h0000;
        sync_n = 1'b0;
        #300;
        for (int i = 0; i < nbits; i++) begin
            // A released line toggles so a stale level never reads as data
            host_din = rel ? ~host_din : wr[15-i];
            #200;
            rd[15-i] = rel ? din_wire : dout;
            sclk     = 1'b1;
            #200;
            sclk = 1'b0;
        end
        #200;
        sync_n   = 1'b1;
        host_din = ~host_din;
        #400;
    endtask

    // Serial clock with frame sync high; the device must ignore it
    task automatic idle_clocks(input logic [15:0] wr, input int nbits);
        for (int i = 0; i < nbits; i++) begin
            host_din = wr[15-i];
            #200;
            sclk = 1'b1;
            #200;
            sclk = 1'b0;
        end
        #400;
    endtask
endmodule

`default_nettype wire

// >>> verification/acsrp_port_test.sv
`timescale 1ns/100ps
`default_nettype none

module acsrp_port_test;
    localparam int CONV = 4;
    localparam int CAL  = 8;
    localparam int PER  = 166;

    logic                   core_clk;
    logic                   srst;
    logic                   sclk;
    logic                   sync_n;
    logic                   host_din;
    logic                   din_in;
    logic                   din_out;
    logic                   din_oe_n;
    logic                   dout;
    logic                   master_clock_in;
    logic [13:0]            result_data;
    logic                   result_valid;
    logic                   result_ready;
    acsrp_pkg::acsrp_core_t core;
    logic [15:0]            rd;
    int                     n_errors;
    int                     checks;
    int                     n_conv;
    int                     n_cal;
    int                     n_busy;

    // ------------------------------------------------------------
    // Clocks, wire resolution, instances
    // ------------------------------------------------------------
    initial core_clk = 1'b0;
    always #25 core_clk = ~core_clk;
    initial master_clock_in = 1'b0;
    always #83 master_clock_in = ~master_clock_in;

    assign din_in = din_oe_n ? host_din : din_out;

    acsrp_port #(.CONV_MCLK(8'h04), .CAL_MCLK(8'h08), .FIFO_DEPTH(32))
    i_acsrp_port (
        .core_clk(core_clk), .srst(srst), .sclk(sclk), .sync_n(sync_n),
        .din_in(din_in), .din_out(din_out), .din_oe_n(din_oe_n),
        .dout(dout), .master_clock_in(master_clock_in),
        .result_data(result_data), .result_valid(result_valid),
        .result_ready(result_ready), .core(core)
    );

    acsrp_host_model i_acsrp_host_model (
        .sclk(sclk), .sync_n(sync_n), .host_din(host_din), .dout(dout),
        .din_wire(din_in)
    );

    always @(posedge core_clk) begin
        if (core.conv_start) n_conv++;
        if (core.cal_start) n_cal++;
        if (core.busy) n_busy++;
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic report_and_stop;
        $display("Errors: %0d  Checks: %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp,
                            input string what);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp, input string what);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %0t: %s got %b expected %b", $time, what, got, exp);
        end
    endtask

    task automatic frame(input logic [15:0] wr, input int n = 16,
                         input logic rel = 1'b0);
        i_acsrp_host_model.xfer(wr, n, rel, rd);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        chk_word({2'b00, core.ctrl}, 16'h0000, "ctrl at reset");
        chk_bit(core.busy, 1'b0, "busy at reset");
        chk_bit(din_oe_n, 1'b1, "data-in released at reset");
        @(negedge core_clk);
        result_data  = 14'h2abc;
        result_valid = 1'b1;
        @(negedge core_clk);
        result_valid = 1'b0;
        frame(16'h0000);
        chk_word(rd, 16'h2abc, "default read source");
    endtask

    task automatic t_test_reg;
        // Test register is written once; later partial-write, idle-clock and two-wire checks reuse its value
        frame(16'h5a5c);
        frame(16'hc040);
        chk_word({2'b00, core.ctrl}, 16'h0040, "ctrl write");
        frame(16'h0123);
        chk_word(rd, 16'h1a5c, "test readback");
        chk_word({2'b00, core.ctrl}, 16'h0040, "ignored address");
        frame(16'h7fff, 10);
        frame(16'hffff, 15);
        frame(16'h0000);
        chk_word(rd, 16'h1a5c, "partial write kept out");
        chk_word({2'b00, core.ctrl}, 16'h0040, "partial ctrl");
        i_acsrp_host_model.idle_clocks(16'h7fff, 16);
        frame(16'h0000);
        chk_word(rd, 16'h1a5c, "clocks outside a frame");
        chk_word({2'b00, core.ctrl}, 16'h0040, "ctrl after idle clocks");
    endtask

    task automatic t_cal;
        frame(16'hc080);
        frame(16'hab3c);
        frame(16'hc080);
        frame(16'h0000);
        chk_word(rd, 16'h2b3c, "calibration readback");
    endtask

    task automatic t_two_wire;
        frame(16'hc060);
        fork
            frame(16'h0000, 16, 1'b1);
            begin
                #1000;
                chk_bit(din_oe_n, 1'b0, "device drives data-in");
            end
        join
        chk_word(rd, 16'h1a5c, "two-wire read");
        chk_bit(din_oe_n, 1'b1, "data-in released");
        chk_word({2'b00, core.ctrl}, 16'h0040, "mode bit cleared");
    endtask

    task automatic t_fifo;
        frame(16'hc000);
        for (int i = 0; i < 32; i++) begin
            @(negedge core_clk);
            chk_bit(result_ready, 1'b1, "fifo accepts");
            result_data  = 14'h3fff - 14'(i);
            result_valid = 1'b1;
        end
        @(negedge core_clk);
        result_valid = 1'b0;
        chk_bit(result_ready, 1'b0, "fifo full refuses");
        for (int i = 0; i < 32; i++) begin
            frame(16'h0000);
            chk_word(rd, {2'b00, 14'h3fff - 14'(i)}, "result read");
        end
        frame(16'hc0c0);
        frame(16'h0000);
        chk_word(rd, 16'h0c00, "status read");
    endtask

    task automatic t_start(input logic [15:0] word, input int mclk,
                           input int e_conv, input int e_cal);
        n_conv = 0;
        n_cal  = 0;
        n_busy = 0;
        frame(word);
        #3000;
        chk_word(16'(n_conv), 16'(e_conv), "conversion pulses");
        chk_word(16'(n_cal), 16'(e_cal), "calibration pulses");
        // Master clock is unrelated in phase, so allow one period either way
        chk_bit(n_busy >= (mclk - 1) * PER / 50 &&
                n_busy <= (mclk + 1) * PER / 50 + 4, 1'b1, "busy span");
        chk_word({2'b00, core.ctrl}, 16'h0000, "start bit cleared");
    endtask

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        srst         = 1'b1;
        result_valid = 1'b0;
        result_data  = 14'h0000;
        n_errors     = 0;
        checks       = 0;
        repeat (5) @(posedge core_clk);
        @(negedge core_clk);
        srst = 1'b0;
        #37;
        t_reset;
        t_test_reg;
        t_cal;
        t_two_wire;
        t_fifo;
        t_start(16'hc010, CONV, 1, 0);
        t_start(16'hc001, CAL, 0, 1);
        t_start(16'hc011, CAL, 0, 1);
        report_and_stop;
    end

    initial begin
        #1000000;
        n_errors++;
        $display("ERROR %0t: watchdog expired", $time);
        report_and_stop;
    end
endmodule

`default_nettype wire
